// ===== src/uart_async_receiver.sv
/*
  asynchronous serial receiver with 16x data recovery, a two-entry
  receive fifo and an apb register slave. assumes pclk at 100 MHz, the
  receive pin asynchronous to pclk, and an apb master that holds each
  request until pready.
*/
`include "uart_rx_regs.svh"
`timescale 1ns/10ps

module uart_async_receiver (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [`ADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               rx_pin,
  output logic                    irq
);

  // register storage
  logic [7:0] rxstat_ctl;
  logic [7:0] txstat_ctl;
  logic [7:0] enables;
  logic [7:0] baud_div;
  logic [7:0] tx_data;
  logic       rx_full_flag;
  logic       overrun_error;

  // fifo: {framing, ninth, data}
  logic [9:0] fifo_mem [0:1];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] fifo_count;
  logic       push;
  logic       pop;
  logic       in_valid;
  logic       in_ready;
  logic [9:0] in_word;
  logic       fifo_full;
  logic       fifo_empty;

  // receiver
  logic                     rx_meta;
  logic                     rx_sync;
  logic                     rx_prev;
  logic [9:0]               tick_cnt;
  logic                     tick16;
  logic [3:0]               sample_cnt;
  logic [3:0]               bit_idx;
  logic [8:0]               shifter;
  uart_rx_pkg::rx_state_type state;
  logic                     rx_enabled;
  logic [9:0]               tick_last;
  logic [3:0]               last_bit;

  // bus
  logic                     access;
  logic                     done;
  logic                     pop_ok;
  uart_rx_pkg::reg_sel_type sel;

  function automatic uart_rx_pkg::reg_sel_type decode(
      input logic [`ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[`ADDR_W-1:2];
    decode = uart_rx_pkg::sel_none;
    if (addr[1:0] == 2'h0) begin
      unique case (idx)
        {2'h0, `IDX_FLAGS}:   decode = uart_rx_pkg::sel_flags;
        {2'h0, `IDX_RXSTAT}:  decode = uart_rx_pkg::sel_rxstat;
        {2'h0, `IDX_TXDATA}:  decode = uart_rx_pkg::sel_txdata;
        {2'h0, `IDX_RXDATA}:  decode = uart_rx_pkg::sel_rxdata;
        {2'h0, `IDX_ENABLES}: decode = uart_rx_pkg::sel_enables;
        {2'h0, `IDX_TXSTAT}:  decode = uart_rx_pkg::sel_txstat;
        {2'h0, `IDX_BAUD}:    decode = uart_rx_pkg::sel_baud;
        default:              decode = uart_rx_pkg::sel_none;
      endcase
    end
  endfunction

  assign sel    = decode(paddr);
  assign access = psel && penable && !pready;
  assign done   = psel && penable && pready;

  // receiver runs only in async mode with port and receive enabled;
  // dropping receive enable parks the frame logic and also clears overrun
  assign rx_enabled = rxstat_ctl[`RS_PORT_EN] && !txstat_ctl[`TS_SYNC_MODE]
                      && rxstat_ctl[`RS_RX_EN];

  // last count of the 16x divider; low-speed range stretches by four
  assign tick_last = txstat_ctl[`TS_FAST_BAUD] ? {2'h0, baud_div}
                     : {baud_div, `LOW_SPEED_MUL};

  // index of the final data bit in a frame
  assign last_bit = rxstat_ctl[`RS_NINE_SEL] ? `BITS_NINE - 4'h1
                    : `BITS_EIGHT - 4'h1;

  // apb handshake: one wait state, pready from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  // read data and error latched in the wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pop_ok  <= 1'b0;
    end else if (access) begin
      pslverr <= (sel == uart_rx_pkg::sel_none);
      pop_ok  <= !pwrite && (sel == uart_rx_pkg::sel_rxdata)
                 && !fifo_empty;
      prdata  <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (sel)
          uart_rx_pkg::sel_flags:
            prdata[`RX_FULL_BIT] <= rx_full_flag;
          uart_rx_pkg::sel_rxstat: begin
            prdata[7:4]      <= rxstat_ctl[7:4];
            // status reflects the word at the fifo head
            prdata[`RS_FRAME_ERR] <= fifo_mem[rd_ptr][`FW_FRAME_ERR];
            prdata[`RS_OVERRUN]   <= overrun_error;
            prdata[`RS_NINTH_BIT] <= fifo_mem[rd_ptr][`FW_NINTH];
          end
          uart_rx_pkg::sel_rxdata:
            prdata[7:0] <= fifo_mem[rd_ptr][7:0];
          uart_rx_pkg::sel_enables:
            prdata[7:0] <= enables;
          uart_rx_pkg::sel_txstat: begin
            prdata[7:0]      <= txstat_ctl;
            // no transmitter here, so its shifter always reads empty
            prdata[`TS_TX_EMPTY] <= 1'b1;
          end
          uart_rx_pkg::sel_baud:
            prdata[7:0] <= baud_div;
          uart_rx_pkg::sel_none,
          uart_rx_pkg::sel_txdata:
            prdata[7:0] <= 8'h00; // write-only and unmapped read zero
        endcase
      end
    end else begin
      pslverr <= 1'b0;
      pop_ok  <= 1'b0;
    end
  end

  // control registers; writes land at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxstat_ctl <= `RST_BYTE;
      txstat_ctl <= `RST_TXSTAT;
      enables    <= `RST_BYTE;
      baud_div   <= `RST_BYTE;
      tx_data    <= `RST_BYTE;
    end else if (done && pwrite) begin
      unique case (sel)
        uart_rx_pkg::sel_rxstat:
          rxstat_ctl <= {pwdata[7:4], 4'h0};
        uart_rx_pkg::sel_txstat: begin
          txstat_ctl <= {pwdata[7:4], 1'b0, pwdata[2], 1'b0,
                         pwdata[0]};
        end
        uart_rx_pkg::sel_enables:
          enables <= pwdata[7:0];
        uart_rx_pkg::sel_baud:
          baud_div <= pwdata[7:0];
        uart_rx_pkg::sel_txdata:
          tx_data <= pwdata[7:0];
        uart_rx_pkg::sel_none,
        uart_rx_pkg::sel_flags,
        uart_rx_pkg::sel_rxdata: begin
          // flag and receive data ignore writes; no error raised
        end
      endcase
    end
  end

  // interrupt request, gated by the receive-full interrupt enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= rx_full_flag && enables[`RX_FULL_BIT];
    end
  end

  // pin synchroniser; only the second stage is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
    end
  end

  // 16x tick: divisor+1 pclks, times four in low-speed range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 10'h000;
      tick16   <= 1'b0;
    end else if (!rx_enabled) begin
      tick_cnt <= 10'h000;
      tick16   <= 1'b0;
    end else begin
      if (tick_cnt == tick_last) begin
        tick_cnt <= 10'h000;
        tick16   <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 10'h001;
        tick16   <= 1'b0;
      end
    end
  end

  // frame state machine on the 16x ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= uart_rx_pkg::rx_idle;
      sample_cnt <= 4'h0;
      bit_idx    <= 4'h0;
      shifter    <= 9'h000;
      rx_prev    <= 1'b1;
      in_valid   <= 1'b0;
      in_word    <= 10'h000;
    end else if (!rx_enabled) begin
      state    <= uart_rx_pkg::rx_idle;
      rx_prev  <= 1'b1;
      in_valid <= 1'b0;
    end else begin
      in_valid <= 1'b0;
      if (tick16) begin
        rx_prev <= rx_sync;
        unique case (state)
          uart_rx_pkg::rx_idle: begin
            if (rx_prev && !rx_sync) begin
              state      <= uart_rx_pkg::rx_start;
              sample_cnt <= 4'h0;
            end
          end
          uart_rx_pkg::rx_start: begin
            if (sample_cnt == `START_MID) begin
              sample_cnt <= 4'h0;
              bit_idx    <= 4'h0;
              shifter    <= 9'h000;
              // glitch shorter than half a bit is not a start
              state <= rx_sync ? uart_rx_pkg::rx_idle
                               : uart_rx_pkg::rx_data;
            end else begin
              sample_cnt <= sample_cnt + 4'h1;
            end
          end
          uart_rx_pkg::rx_data: begin
            if (sample_cnt == `OVERSAMPLE_LAST) begin
              sample_cnt        <= 4'h0;
              shifter[bit_idx]  <= rx_sync;
              bit_idx           <= bit_idx + 4'h1;
              if (bit_idx == last_bit) begin
                state <= uart_rx_pkg::rx_stop;
              end
            end else begin
              sample_cnt <= sample_cnt + 4'h1;
            end
          end
          uart_rx_pkg::rx_stop: begin
            if (sample_cnt == `OVERSAMPLE_LAST) begin
              sample_cnt <= 4'h0;
              state      <= uart_rx_pkg::rx_idle;
              in_valid   <= 1'b1;
              // stop sampled low marks a framing error
              in_word <= {!rx_sync,
                          rxstat_ctl[`RS_NINE_SEL] & shifter[8],
                          shifter[7:0]};
            end else begin
              sample_cnt <= sample_cnt + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // fifo accepts only with room and no pending overrun
  // occupancy decodes shared by the push gate, overrun and pop
  assign fifo_full  = (fifo_count == `FIFO_DEPTH);
  assign fifo_empty = (fifo_count == 2'h0);
  assign in_ready = !fifo_full && !overrun_error;
  assign push     = in_valid && in_ready;
  assign pop      = done && pop_ok;

  // one word register per entry, loaded only when the write pointer
  // selects it
  for (genvar e = 0; e < `FIFO_DEPTH; e++) begin : g_entry
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fifo_mem[e] <= 10'h000;
      end else if (push && wr_ptr == 1'(e)) begin
        fifo_mem[e] <= in_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr      <= 1'b0;
      rd_ptr      <= 1'b0;
      fifo_count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      if (push && !pop) begin
        fifo_count <= fifo_count + 2'h1;
      end else if (pop && !push) begin
        fifo_count <= fifo_count - 2'h1;
      end
    end
  end

  // receive-full tracks fifo occupancy; software cannot write it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full_flag <= 1'b0;
    end else begin
      // push in the same cycle as the last pop keeps the flag set
      rx_full_flag <= push || (fifo_count > 2'h1)
                      || (fifo_count == 2'h1 && !pop);
    end
  end

  // overrun: set on full fifo at stop, cleared with receive disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error <= 1'b0;
    end else begin
      // set wins over a clear that falls in the same cycle
      if (in_valid && fifo_full) begin
        overrun_error <= 1'b1;
      end else if (!rxstat_ctl[`RS_RX_EN]) begin
        overrun_error <= 1'b0;
      end
    end
  end

endmodule

// ===== src/uart_rx_regs.svh
/*
  register map, field positions, reset values and timing counts of the
  asynchronous serial receiver; assumes a 32-bit apb slave where each
  register index maps to byte address four times the index.
*/
`ifndef UART_RX_REGS_SVH
`define UART_RX_REGS_SVH

`define ADDR_W          12
// register indices as printed; byte address is four times these
`define IDX_FLAGS       8'h0C
`define IDX_RXSTAT      8'h18
`define IDX_TXDATA      8'h19
`define IDX_RXDATA      8'h1A
`define IDX_ENABLES     8'h8C
`define IDX_TXSTAT      8'h98
`define IDX_BAUD        8'h99

// receive status/control fields
`define RS_PORT_EN      7
`define RS_NINE_SEL     6
`define RS_SINGLE_RX    5
`define RS_RX_EN        4
`define RS_FRAME_ERR    2
`define RS_OVERRUN      1
`define RS_NINTH_BIT    0
// transmit status/control fields
`define TS_CLK_SRC      7
`define TS_TX_NINE      6
`define TS_TX_EN        5
`define TS_SYNC_MODE    4
`define TS_FAST_BAUD    2
`define TS_TX_EMPTY     1
`define TS_TX_NINTH     0
// fields of a queued fifo word above its eight data bits
`define FW_FRAME_ERR    9
`define FW_NINTH        8
// flag and enable position of the receive-full event
`define RX_FULL_BIT     5

`define RST_BYTE        8'h00
`define RST_TXSTAT      8'h02

// sixteen samples per bit, mid-bit at sample seven after the edge
`define OVERSAMPLE_LAST 4'hF
`define START_MID       4'h7
`define LOW_SPEED_MUL   2'h3
`define BITS_EIGHT      4'h8
`define BITS_NINE       4'h9
`define FIFO_DEPTH      2'h2

`endif

// ===== src/uart_rx_pkg.sv
/*
  types shared by the asynchronous serial receiver; no assumptions.
*/
package uart_rx_pkg;

  typedef enum logic [1:0] {
    rx_idle,
    rx_start,
    rx_data,
    rx_stop
  } rx_state_type;

  typedef enum logic [2:0] {
    sel_none,
    sel_flags,
    sel_rxstat,
    sel_txdata,
    sel_rxdata,
    sel_enables,
    sel_txstat,
    sel_baud
  } reg_sel_type;

endpackage

// ===== tb/uart_line_driver.sv
/*
  remote transmitter model driving the receive line.
  assumes the bench calls send and the line is pulled up when idle.
*/
`timescale 1ns/10ps
module uart_line_driver #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic pclk,
  output logic      line
);
  // idle high, as the pull-up holds it between frames
  initial line = 1'b1;
  task automatic send(input logic [8:0] w, input logic nine,
                      input logic stop);
    logic [10:0] f;
    int          n;
    // start low, data lsb first, optional ninth bit, stop
    f = nine ? {stop, w, 1'b0} : {1'b1, stop, w[7:0], 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      line <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge pclk);
    end
    @(posedge pclk);
    line <= 1'b1;
    // room for the word to land before software looks
    repeat (3 * BIT_CYCLES) @(posedge pclk);
  endtask
endmodule

// ===== tb/uart_async_receiver_chk.sv
/*
  port checker for the receiver.
  assumes one clock pclk and reset presetn; bound to the receiver.
*/
`include "uart_rx_regs.svh"
`timescale 1ns/10ps
module uart_async_receiver_chk (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               rx_pin,
  input wire logic               irq
);
  localparam logic [11:0] a_en = {2'h0, `IDX_ENABLES, 2'h0};
  localparam logic [11:0] a_rs = {2'h0, `IDX_RXSTAT, 2'h0};
  // shadow of the receive interrupt enable
  logic en_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else if (pready && pwrite && !pslverr && paddr == a_en) begin
      en_q <= pwdata[`RX_FULL_BIT];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  wait_state_a: assert property (setup_s ##1 access_s |=> pready)
    else $error("no answer one cycle into access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  misalign_err_a: assert property (pready && paddr[1:0] != 2'h0
    |-> pslverr) else $error("misaligned access not refused");
  err_zero_a: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0) else $error("refused read not zero");
  irq_masked_a: assert property (irq |-> en_q || $past(en_q))
    else $error("interrupt while disabled");
  gap_zero_a: assert property (pready && !pwrite && paddr == a_rs
    |-> !prdata[3]) else $error("unused status bit set");
endmodule
bind uart_async_receiver uart_async_receiver_chk chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .rx_pin, .irq);

// ===== tb/uart_async_receiver_tb_top.sv
/*
  self-checking bench for the receiver.
  assumes 16 pclk bit time: divisor 0 with high speed select, and
  64 pclk bit time in the low-speed range with divisor 0.
*/
`include "uart_rx_regs.svh"
`timescale 1ns/10ps
module uart_async_receiver_tb_top;
  localparam logic [11:0] a_fl = {2'h0, `IDX_FLAGS, 2'h0};
  localparam logic [11:0] a_rs = {2'h0, `IDX_RXSTAT, 2'h0};
  localparam logic [11:0] a_rd = {2'h0, `IDX_RXDATA, 2'h0};
  localparam logic [11:0] a_en = {2'h0, `IDX_ENABLES, 2'h0};
  localparam logic [11:0] a_ts = {2'h0, `IDX_TXSTAT, 2'h0};
  localparam logic [11:0] a_bd = {2'h0, `IDX_BAUD, 2'h0};
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               line;
  logic               line_slow;
  logic               rx_line;
  logic               irq;
  logic [31:0]        rq;
  logic               rerr;
  int                 mismatches;
  int                 comparisons;
  uart_async_receiver dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_line), .irq(irq));
  uart_line_driver tx (.pclk(pclk), .line(line));
  uart_line_driver #(.BIT_CYCLES(64)) tx_slow (.pclk(pclk),
    .line(line_slow));
  // both transmitters idle high, so the shared line is their and
  assign rx_line = line & line_slow;
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string what);
    apb(1'b0, a, 32'h0);
    check(rq, e, what);
  endtask
  task automatic t_reset();
    rd(a_fl, 32'h0, "flags");
    rd(a_rs, 32'h0, "rx status");
    rd(a_ts, 32'h2, "tx status");
    rd(a_en, 32'h0, "enables");
    rd(a_bd, 32'h0, "divisor");
    rd(a_rd, 32'h0, "rx data");
    apb(1'b0, 12'h004, 32'h0);
    check({31'h0, rerr}, 32'h1, "unmapped");
    apb(1'b0, 12'h061, 32'h0);
    check({31'h0, rerr}, 32'h1, "misaligned");
    wr(a_fl, 32'hFF);
    rd(a_fl, 32'h0, "flag write");
    $display("test reset done");
  endtask
  task automatic t_setup();
    wr(a_bd, 32'h0);
    wr(a_ts, 32'h4);
    wr(a_en, 32'h20);
    wr(a_rs, 32'h80);
    tx.send(9'h0A5, 1'b0, 1'b1);
    rd(a_fl, 32'h0, "not enabled");
    wr(a_rs, 32'h90);
    $display("test setup done");
  endtask
  task automatic t_overrun();
    tx.send(9'h0A5, 1'b0, 1'b1);
    tx.send(9'h03C, 1'b0, 1'b1);
    tx.send(9'h081, 1'b0, 1'b1);
    check({31'h0, irq}, 32'h1, "irq");
    rd(a_fl, 32'h20, "full");
    rd(a_rs, 32'h92, "overrun");
    rd(a_rd, 32'hA5, "first");
    rd(a_rd, 32'h3C, "second");
    rd(a_fl, 32'h0, "empty");
    tx.send(9'h066, 1'b0, 1'b1);
    rd(a_fl, 32'h0, "blocked");
    wr(a_rs, 32'h80);
    wr(a_rs, 32'h90);
    rd(a_rs, 32'h90, "cleared");
    tx.send(9'h05A, 1'b0, 1'b1);
    rd(a_rd, 32'h5A, "after clear");
    $display("test overrun done");
  endtask
  task automatic t_nine();
    wr(a_en, 32'h0);
    wr(a_rs, 32'hD0);
    tx.send(9'h155, 1'b1, 1'b1);
    tx.send(9'h012, 1'b1, 1'b0);
    check({31'h0, irq}, 32'h0, "masked");
    rd(a_fl, 32'h20, "flag only");
    rd(a_rs, 32'hD1, "ninth");
    rd(a_rd, 32'h55, "word one");
    rd(a_rs, 32'hD4, "framing");
    rd(a_rd, 32'h12, "word two");
    $display("test nine done");
  endtask
  task automatic t_slow();
    wr(a_rs, 32'h90);
    wr(a_ts, 32'h14);
    tx.send(9'h0C3, 1'b0, 1'b1);
    rd(a_fl, 32'h0, "sync mode");
    wr(a_ts, 32'h0);
    tx_slow.send(9'h0C3, 1'b0, 1'b1);
    rd(a_fl, 32'h20, "slow full");
    rd(a_rs, 32'h90, "slow status");
    rd(a_rd, 32'hC3, "slow word");
    rd(a_fl, 32'h0, "slow empty");
    $display("test slow done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_setup();
    t_overrun();
    t_nine();
    t_slow();
    tally_and_finish();
  end
endmodule
